// file: src/mme_top.sv
// Operation
// - Normal monitor: high IRQ, port pattern 1010
// - Normal monitor divider pin 0 ref clock, 1 half
// - Forced monitor without high voltage, blank vectors
// - Forced: IRQ normal, reset normal, A=10
// - Forced monitor ignores all port B pins
// - Watchdog always disabled in forced monitor
// - Normal monitor: watchdog off while high voltage
// - Afterwards only software disable bit stops watchdog
`include "mme_cfg.svh"
module mme_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Entry pins
  input wire logic i_irq_test_high_voltage,
  input wire logic i_rst_test_high_voltage,
  input wire logic i_port_a_bit0,
  input wire logic i_port_a_bit1,
  input wire logic i_port_b_bit0,
  input wire logic i_port_b_bit1,
  input wire logic i_divider_select_pin,
  // Reset vector bytes
  input wire logic [7:0] i_rst_vec_hi,
  input wire logic [7:0] i_rst_vec_lo,
  // Software disable bit from first config register
  input wire logic i_watchdog_disable_bit,
  // Mode and clocking
  output logic o_normal_mon,
  output logic o_forced_mon,
  output logic o_gen_half,
  output logic o_gen_en,
  output logic o_bus_en,
  output logic o_watchdog_disable
);
  // Mode group
  mme_pkg::mme_mode_t mode_q;
  mme_pkg::mme_mode_t mode_d;
  logic normal_q;
  logic normal_d;
  logic forced_q;
  logic forced_d;

  // Arm and divider groups
  logic armed_q;
  logic armed_d;
  logic half_q;
  logic half_d;

  // Watchdog group
  logic wd_q;
  logic wd_d;

  // Enable group
  logic gen_en_w;
  logic bus_en_w;
  logic gen_en_q;
  logic gen_en_d;
  logic bus_en_q;
  logic bus_en_d;

  // Entry decode
  logic pa0_ok;
  logic pa1_ok;
  logic pb0_ok;
  logic pb1_ok;
  logic hi_blank;
  logic lo_blank;
  logic blank;
  logic a_ok;
  logic b_ok;
  logic irq_hv;
  logic rst_hv;
  logic any_hv;
  logic normal_ok;
  logic forced_ok;
  logic div_ref;

  // Each entry pin compared on its own against its level
  always_comb begin
    pa0_ok = (i_port_a_bit0 == `MME_PA0_ENTRY);
    pa1_ok = (i_port_a_bit1 == `MME_PA1_ENTRY);
    pb0_ok = (i_port_b_bit0 == `MME_PB0_ENTRY);
    pb1_ok = (i_port_b_bit1 == `MME_PB1_ENTRY);
    hi_blank = (i_rst_vec_hi == `MME_BLANK_BYTE);
    lo_blank = (i_rst_vec_lo == `MME_BLANK_BYTE);
    blank = hi_blank && lo_blank;
    a_ok = pa0_ok && pa1_ok;
    b_ok = pb0_ok && pb1_ok;
    irq_hv = i_irq_test_high_voltage;
    rst_hv = i_rst_test_high_voltage;
    any_hv = irq_hv || rst_hv;
    normal_ok = irq_hv && a_ok && b_ok;
    // Port B left out: forced entry needs no fixture on it
    forced_ok = !any_hv && a_ok && blank;
    div_ref = (i_divider_select_pin == `MME_DIVSEL_REF);
  end

  // Arm flag marks the single sampling cycle after release
  always_comb begin
    armed_d = armed_q;
    if (!armed_q) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // Pins caught on first clock after release; mode then frozen
  always_comb begin
    mode_d = mode_q;
    normal_d = normal_q;
    forced_d = forced_q;
    if (!armed_q) begin
      if (normal_ok) begin
        mode_d = mme_pkg::MME_NORMAL_MON;
      end else if (forced_ok) begin
        mode_d = mme_pkg::MME_FORCED_MON;
      end else begin
        mode_d = mme_pkg::MME_USER;
      end
      // Flags kept in flops so outputs carry no decode
      normal_d = (mode_d == mme_pkg::MME_NORMAL_MON);
      forced_d = (mode_d == mme_pkg::MME_FORCED_MON);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mode_q <= mme_pkg::MME_USER;
      normal_q <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      normal_q <= normal_d;
      forced_q <= forced_d;
    end
  end

  // Forced and user entry ignore the divider pin
  always_comb begin
    half_d = half_q;
    if (!armed_q) begin
      half_d = 1'b1;
      if (normal_ok) begin
        half_d = !div_ref;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      half_q <= `MME_HALF_RST;
    end else begin
      half_q <= half_d;
    end
  end

  // Watchdog disable follows high voltage live in normal monitor
  always_comb begin
    case (mode_q)
      mme_pkg::MME_FORCED_MON: begin
        wd_d = 1'b1;
      end
      mme_pkg::MME_NORMAL_MON: begin
        wd_d = any_hv || i_watchdog_disable_bit;
      end
      mme_pkg::MME_USER: begin
        wd_d = i_watchdog_disable_bit;
      end
      default: begin
        wd_d = `MME_WD_DIS_RST;
      end
    endcase
    // Mode not yet settled on the sampling cycle
    if (!armed_q) begin
      wd_d = `MME_WD_DIS_RST;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wd_q <= `MME_WD_DIS_RST;
    end else begin
      wd_q <= wd_d;
    end
  end

  // Enables re-timed so every output leaves a flip-flop
  always_comb begin
    gen_en_d = gen_en_w;
    bus_en_d = bus_en_w;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      gen_en_q <= 1'b0;
      bus_en_q <= 1'b0;
    end else begin
      gen_en_q <= gen_en_d;
      bus_en_q <= bus_en_d;
    end
  end

  // Divider runs from reset so enables settle early
  mme_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_half(half_q),
    .o_gen_en(gen_en_w),
    .o_bus_en(bus_en_w)
  );

  assign o_normal_mon = normal_q;
  assign o_forced_mon = forced_q;
  assign o_gen_half = half_q;
  assign o_gen_en = gen_en_q;
  assign o_bus_en = bus_en_q;
  assign o_watchdog_disable = wd_q;
endmodule

// file: src/mme_cfg.svh
`ifndef MME_CFG_SVH
`define MME_CFG_SVH
`define MME_PA0_ENTRY 1'b1
`define MME_PA1_ENTRY 1'b0
`define MME_PB0_ENTRY 1'b1
`define MME_PB1_ENTRY 1'b0
`define MME_BLANK_BYTE 8'hff
`define MME_DIVSEL_REF 1'b0
`define MME_WD_DIS_RST 1'b0
`define MME_HALF_RST 1'b1
`endif

// file: src/mme_pkg.sv
package mme_pkg;
  typedef enum logic [1:0] {
    MME_USER,
    MME_NORMAL_MON,
    MME_FORCED_MON
  } mme_mode_t;
endpackage

// file: src/mme_div.sv
`include "mme_cfg.svh"
module mme_div (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Control
  input wire logic i_half,
  // Enables
  output logic o_gen_en,
  output logic o_bus_en
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q + 2'h1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Generator output is reference or half; bus always half of generator
  assign o_gen_en = i_half ? cnt_q[0] : 1'b1;
  assign o_bus_en = i_half ? (cnt_q == 2'h3) : cnt_q[0];
endmodule

// file: test/mme_host.sv
module mme_host (
  // Requested pin levels
  input wire logic [7:0] i_cfg,
  // Entry pins toward the device
  output logic [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Held steady across reset release, where the device samples the entry pins
  assign o_pins = i_cfg;
endmodule

// file: test/mme_top_asserts.sv
module mme_top_asserts (
  input wire logic i_clk_sys, i_rst_b, i_irq_test_high_voltage,
  input wire logic i_rst_test_high_voltage, i_port_a_bit0, i_port_a_bit1,
  input wire logic i_port_b_bit0, i_port_b_bit1, i_divider_select_pin,
  input wire logic [7:0] i_rst_vec_hi, i_rst_vec_lo,
  input wire logic i_watchdog_disable_bit, o_normal_mon, o_forced_mon,
  input wire logic o_gen_half, o_bus_en, o_watchdog_disable
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic pa = i_port_a_bit0 && !i_port_a_bit1;
  wire logic hv = i_irq_test_high_voltage || i_rst_test_high_voltage;
  wire logic nm = i_irq_test_high_voltage && pa && i_port_b_bit0 &&
    !i_port_b_bit1;
  wire logic fm = !hv && pa && (i_rst_vec_hi & i_rst_vec_lo) == 8'hff;
  wire logic nr = nm && !i_divider_select_pin;
  wire logic nh = o_normal_mon && hv;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_e; $rose(i_rst_b); endsequence
  property p_nm; s_e |=> o_normal_mon == $past(nm); endproperty
  a_nm: assert property (p_nm) else $error("normal");
  property p_fm; s_e |=> o_forced_mon == $past(fm); endproperty
  a_fm: assert property (p_fm) else $error("forced");
  property p_dv; s_e |=> o_gen_half == !$past(nr); endproperty
  a_dv: assert property (p_dv) else $error("divider");
  property p_hd; !$rose(i_rst_b) |=> $stable({o_normal_mon, o_forced_mon,
    o_gen_half}); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_wf; o_forced_mon |=> o_watchdog_disable; endproperty
  a_wf: assert property (p_wf) else $error("wd forced");
  property p_wn; o_normal_mon |=> o_watchdog_disable ==
    ($past(nh) || $past(i_watchdog_disable_bit)); endproperty
  a_wn: assert property (p_wn) else $error("wd normal");
  property p_wu; !$rose(i_rst_b) && !o_normal_mon && !o_forced_mon |=>
    o_watchdog_disable == $past(i_watchdog_disable_bit); endproperty
  a_wu: assert property (p_wu) else $error("wd user");
  property p_bs; o_bus_en |=> !o_bus_en; endproperty
  a_bs: assert property (p_bs) else $error("bus rate");
endmodule
bind mme_top mme_top_asserts u_chk (.*);

// file: test/monitor_mode_entry_select_bench.sv
module monitor_mode_entry_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys = 0, i_rst_b = 0, en, ef, h;
  logic [7:0] i_rst_vec_hi = 0, i_rst_vec_lo = 0, cfg = 0, x, p;
  logic o_normal_mon, o_forced_mon, o_gen_half, o_gen_en, o_bus_en;
  logic o_watchdog_disable;
  logic [31:0] r;
  int errors = 0, checks_done = 0, seed = 32'hbf2e, cyc = 0, n, m;
  mme_host host_u (.i_cfg(cfg), .o_pins(p));
  mme_top dut_u (.*, .i_irq_test_high_voltage(p[0]),
    .i_rst_test_high_voltage(p[1]), .i_port_a_bit0(p[2]),
    .i_port_a_bit1(p[3]), .i_port_b_bit0(p[4]), .i_port_b_bit1(p[5]),
    .i_divider_select_pin(p[6]), .i_watchdog_disable_bit(p[7]));
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic a, input logic e);
    checks_done++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED %0t output mismatch", $time);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge i_clk_sys) if (++cyc == 20000) begin
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(negedge i_clk_sys);
    repeat (150) begin
      r = $random(seed);
      // Bias lowers bits 0, 2 and 4, so normal monitor entry is rarer than unbiased
      cfg = (r[7:0] | {3'h0, r[12], 1'b0, r[10], 2'h0}) &
        {3'h7, ~r[13], 1'b1, ~r[11], 1'b1, ~r[9]};
      i_rst_vec_hi = r[14] ? 8'hff : r[23:16];
      i_rst_vec_lo = r[15] ? 8'hff : r[31:24];
      en = cfg[0] && cfg[2] && !cfg[3] && cfg[4] && !cfg[5];
      ef = !cfg[0] && !cfg[1] && cfg[2] && !cfg[3] &&
        (i_rst_vec_hi & i_rst_vec_lo) == 8'hff;
      h = !(en && !cfg[6]);
      i_rst_b = 0;
      @(negedge i_clk_sys) i_rst_b = 1;
      repeat (2) @(negedge i_clk_sys);
      chk(o_normal_mon, en);
      chk(o_forced_mon, ef);
      chk(o_gen_half, h);
      n = 0;
      m = 0;
      repeat (8) begin
        cfg = $random(seed);
        x = cfg;
        @(negedge i_clk_sys);
        chk(o_watchdog_disable,
          ef || en && (x[0] || x[1]) || x[7]);
        n += o_gen_en;
        m += o_bus_en;
      end
      chk(n == (h ? 4 : 8) && m == (h ? 2 : 4), 1);
      chk(o_normal_mon, en);
    end
    report_and_stop;
  end
endmodule
